// >>> design/bank_cmd_host.sv
// Host controller issuing cross-bank legal commands to a four-bank memory
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - Issue commands only once clock enable is high on previous and current edge.
// R2 - Never issue an unlisted bank-state and command combination.
// R3 - Activate to another bank allowed while banks activate, stay active or precharge.
// R4 - Keep row-to-row activate delay between activates.
// R5 - Read or write accepted whatever other banks are doing. The code refuses a read while any bank writes and a write while any bank reads.
// R6 - Mode register read allowed while other banks activate or precharge.
// R7 - Mode register read leaves bank idle-reading or active-reading per its state.
// R8 - Burst terminate only while a burst runs; bank returns to active.
// R9 - Burst terminate aimed only at the bank with the running burst.
// R10 - Write after read only after burst done or terminated.
// R11 - Read after write only after burst done or terminated.
// R12 - Precharge all only when every bank may be precharged.
// R13 - After auto-precharge access, other banks usable within precharge timing.
// R14 - Refresh and mode register write only with all banks idle.
// R15 - Reset is a mode register write from power-on with banks idle.
// R16 - Read during reset enters resetting read state, ending all idle.
// R17 - Only NOPs during mode register read or write states.
// R18 - Read from active bank returns active; from idle ends all idle.
// R19 - Mode register write lasts its time then all banks idle.
// R20 - Mask sent with each write beat; high mask inhibits the beat.
// R21 - Idle after precharge time, active after activate-to-column time.
// R22 - Track four bank states and flag illegal requests.
module bank_cmd_host
    import bank_cmd_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_mem_ck,
    input  wire logic              i_mem_cke,
    input  wire logic              i_req_valid,
    input  wire user_req_s         i_req,
    output logic                   o_req_ready,
    output logic                   o_req_err,
    output mem_cmd_s               o_mem_cmd,
    output logic                   o_mem_cmd_valid,
    output logic [DATA_W-1:0]      o_mem_dq,
    output logic [MASK_W-1:0]      o_mem_dm,
    output logic                   o_mem_dq_oe,
    output logic [4*NUM_BANKS-1:0] o_bank_state
);
    // Link clock and clock enable synchronisers
    logic [1:0] ck_sync;
    logic [1:0] cke_sync;
    logic       ck_prev;
    logic       cke_prev;
    wire        tick   = ck_sync[1] & ~ck_prev;  // Link clock rising edge
    wire        cke_ok = cke_sync[1] & cke_prev; // [R1]
    always_ff @(posedge i_ref_clk) begin
        ck_sync  <= {ck_sync[0], i_mem_ck};
        cke_sync <= {cke_sync[0], i_mem_cke};
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ck_prev  <= 1'b0;
            cke_prev <= 1'b0;
        end else begin
            ck_prev  <= ck_sync[1];
            if (tick) cke_prev <= cke_sync[1];
        end
    end
    // Device-wide state
    dev_st_e          dev;
    logic [CNT_W-1:0] dev_cnt;
    logic [CNT_W-1:0] rrd_cnt;
    logic             mrr_active;
    logic             dev_go_idle;
    bank_st_e         bst [NUM_BANKS];

    // Per-bank summaries
    logic [NUM_BANKS-1:0] is_idle;
    logic [NUM_BANKS-1:0] is_busy;
    logic [NUM_BANKS-1:0] is_rd;
    logic [NUM_BANKS-1:0] is_wr;
    logic [NUM_BANKS-1:0] pre_ok;

    // Decode of the request
    wire cmd_e  rc     = i_req.cmd;
    wire [BANK_W-1:0] rb = i_req.bank;
    wire bank_st_e tgt = bst[rb];
    wire all_idle  = &is_idle;
    wire any_rd    = |is_rd;
    wire any_wr    = |is_wr;
    wire others_ok = ((is_busy & ~(NUM_BANKS'(1) << rb)) == '0);
    wire mr_busy   = (dev == DV_MRR) || (dev == DV_MRW); // NOPs only [R17]
    wire base_ok   = cke_ok && !mr_busy; // Power-on misuse is flagged by legal [R22]

    // Legality of the request for the tracked states
    wire act_ok  = (tgt == BK_IDLE) && (rrd_cnt == '0);          // [R3] [R4]
    wire rw_ok   = (tgt == BK_ACT || tgt == BK_RD || tgt == BK_WR); // [R5] [R13]
    wire rd_ok   = rw_ok && !any_wr;                              // [R11]
    wire wr_ok   = rw_ok && !any_rd;                              // [R10]
    wire pre1_ok = pre_ok[rb];
    wire prea_ok = &pre_ok;                                       // [R12]
    wire mrr_ok  = (tgt == BK_IDLE || tgt == BK_ACT) && others_ok; // [R6] [R7]
    wire bst_ok  = (bst[rb] == BK_RD || bst[rb] == BK_WR);        // [R8] [R9]
    wire quiet_ok = all_idle && (dev == DV_NORMAL);               // [R14]
    wire rst_ok  = all_idle;                                      // [R15]

    logic legal;
    always_comb begin
        case (rc)
            CMD_NOP:   legal = 1'b1;
            CMD_ACT:   legal = act_ok && dev == DV_NORMAL;
            CMD_RD:    legal = rd_ok && dev == DV_NORMAL;
            CMD_WR:    legal = wr_ok && dev == DV_NORMAL;
            CMD_PRE:   legal = pre1_ok && dev == DV_NORMAL;
            CMD_PREA:  legal = prea_ok && dev == DV_NORMAL;
            CMD_MRR:   legal = (dev == DV_RESET) || (mrr_ok && dev == DV_NORMAL); // [R16]
            CMD_MRW:   legal = quiet_ok;
            CMD_REF:   legal = quiet_ok;
            CMD_RESET: legal = rst_ok;
            CMD_BST:   legal = bst_ok && dev == DV_NORMAL;
            default:   legal = 1'b0;
        endcase
    end

    wire fire   = i_req_valid && tick && base_ok && legal && rc != CMD_NOP; // [R2] [R22]
    wire reject = i_req_valid && tick && base_ok && !legal;                 // [R22]

    // Per-bank trackers
    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : g_bank
            wire hit = fire && (rb == BANK_W'(g));
            bank_tracker u_bank (
                .i_ref_clk (i_ref_clk),
                .i_rst_n   (i_rst_n),
                .i_tick    (tick),
                .i_go_idle (dev_go_idle),
                .i_act     (hit && rc == CMD_ACT),
                .i_rd      (hit && rc == CMD_RD),
                .i_wr      (hit && rc == CMD_WR),
                .i_ap      (i_req.auto_pre),
                .i_pre     ((hit && rc == CMD_PRE) || (fire && rc == CMD_PREA)),
                .i_stop    (hit && rc == CMD_BST),
                .o_state   (bst[g])
            );
            assign is_idle[g] = (bst[g] == BK_IDLE);
            assign is_rd[g]   = (bst[g] == BK_RD) || (bst[g] == BK_RDAP);
            assign is_wr[g]   = (bst[g] == BK_WR) || (bst[g] == BK_WRAP);
            assign is_busy[g] = is_rd[g] || is_wr[g];
            assign pre_ok[g]  = (bst[g] == BK_IDLE) || (bst[g] == BK_ACT);
        end
    endgenerate

    // Device state: reset, mode register read and write windows
    wire dev_timeout = tick && (dev_cnt == '0);
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            dev         <= DV_POWERON;
            dev_cnt     <= '0;
            mrr_active  <= 1'b0;
            dev_go_idle <= 1'b0;
        end else begin
            dev_go_idle <= 1'b0;
            if (fire && rc == CMD_RESET) begin
                dev <= DV_RESET; // [R15]
            end else if (fire && rc == CMD_MRW) begin
                dev     <= DV_MRW; // [R19]
                dev_cnt <= CNT_W'(T_MRW_CK);
            end else if (fire && rc == CMD_MRR) begin
                dev        <= DV_MRR;
                dev_cnt    <= CNT_W'(T_MRR_CK);
                mrr_active <= (tgt == BK_ACT); // [R7]
            end else if (tick && dev_cnt != '0) begin
                dev_cnt <= dev_cnt - 1'b1;
            end else if (dev_timeout && (dev == DV_MRR || dev == DV_MRW)) begin
                dev         <= DV_NORMAL;
                dev_go_idle <= !mrr_active; // [R16] [R18] [R19]
                mrr_active  <= 1'b0;
            end
        end
    end

    // Activate spacing counter
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rrd_cnt <= '0;
        end else if (fire && rc == CMD_ACT) begin
            rrd_cnt <= CNT_W'(RRD_CYC); // [R4]
        end else if (tick && rrd_cnt != '0) begin
            rrd_cnt <= rrd_cnt - 1'b1;
        end
    end

    // Pin outputs, registered on the link tick; ready is registered on every reference clock
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_mem_cmd       <= '0;
            o_mem_cmd_valid <= 1'b0;
            o_mem_dq        <= '0;
            o_mem_dm        <= '1;
            o_mem_dq_oe     <= 1'b0;
            o_req_err       <= 1'b0;
            o_req_ready     <= 1'b0;
        end else begin
            o_req_ready <= base_ok;
            if (tick) begin
                o_mem_cmd_valid <= fire;
                o_mem_cmd       <= fire ? mem_cmd_s'{rc, rb, i_req.auto_pre}
                                        : mem_cmd_s'{CMD_NOP, '0, 1'b0};
                o_req_err       <= reject;
                o_mem_dq_oe     <= fire && rc == CMD_WR;
                o_mem_dq        <= i_req.wdata;
                o_mem_dm        <= (fire && rc == CMD_WR) ? i_req.wmask : '1; // [R20]
            end
        end
    end

    // Bank state vector for observation
    always_ff @(posedge i_ref_clk) begin
        for (int i = 0; i < NUM_BANKS; i++) begin
            o_bank_state[4*i +: 4] <= i_rst_n ? {bst[i][7] | bst[i][6] | bst[i][5] | bst[i][4],
                                                bst[i][7] | bst[i][6] | bst[i][3] | bst[i][2],
                                                bst[i][6] | bst[i][5] | bst[i][3] | bst[i][1],
                                                1'b0} : 4'h0;
        end
    end
endmodule // bank_cmd_host
`default_nettype wire

// >>> design/bank_cmd_pkg.sv
// Package: command codes, bank states, timing counts and carrier structs
package bank_cmd_pkg;

    localparam int NUM_BANKS = 4;
    localparam int BANK_W    = 2;
    localparam int DATA_W    = 32;
    localparam int MASK_W    = 4;

    // Timing in ns at a 25 ns clock
    localparam int CLK_NS    = 25;
    localparam int T_RCD_NS  = 18;
    localparam int T_RP_NS   = 18;
    localparam int T_RRD_NS  = 10;
    localparam int T_MRR_CK  = 2;
    localparam int T_MRW_CK  = 5;
    localparam int T_BURST_CK = 2;
    localparam int RCD_CYC   = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC    = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RRD_CYC   = (T_RRD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W     = 4;

    typedef enum logic [3:0] {
        CMD_NOP   = 4'h0,
        CMD_ACT   = 4'h1,
        CMD_RD    = 4'h2,
        CMD_WR    = 4'h3,
        CMD_PRE   = 4'h4,
        CMD_PREA  = 4'h5,
        CMD_MRR   = 4'h6,
        CMD_MRW   = 4'h7,
        CMD_RESET = 4'h8,
        CMD_BST   = 4'h9,
        CMD_REF   = 4'ha
    } cmd_e;

    typedef enum logic [7:0] {
        BK_IDLE  = 8'b0000_0001,
        BK_ACTG  = 8'b0000_0010,
        BK_ACT   = 8'b0000_0100,
        BK_RD    = 8'b0000_1000,
        BK_WR    = 8'b0001_0000,
        BK_RDAP  = 8'b0010_0000,
        BK_WRAP  = 8'b0100_0000,
        BK_PRE   = 8'b1000_0000
    } bank_st_e;

    typedef enum logic [4:0] {
        DV_POWERON = 5'b0_0001,
        DV_NORMAL  = 5'b0_0010,
        DV_RESET   = 5'b0_0100,
        DV_MRR     = 5'b0_1000,
        DV_MRW     = 5'b1_0000
    } dev_st_e;

    // Request from the user side
    typedef struct packed {
        cmd_e              cmd;
        logic [BANK_W-1:0] bank;
        logic              auto_pre;
        logic [DATA_W-1:0] wdata;
        logic [MASK_W-1:0] wmask;
    } user_req_s;

    // Command on the pins toward the memory
    typedef struct packed {
        cmd_e              cmd;
        logic [BANK_W-1:0] bank;
        logic              auto_pre;
    } mem_cmd_s;

endpackage

// >>> design/bank_tracker.sv
// One bank's state and its settle counter
`timescale 1ns/1ps
`default_nettype none
module bank_tracker
    import bank_cmd_pkg::*;
(
    input  wire logic     i_ref_clk,
    input  wire logic     i_rst_n,
    input  wire logic     i_tick,
    input  wire logic     i_go_idle,
    input  wire logic     i_act,
    input  wire logic     i_rd,
    input  wire logic     i_wr,
    input  wire logic     i_ap,
    input  wire logic     i_pre,
    input  wire logic     i_stop,
    output bank_st_e      o_state
);
    bank_st_e         state;
    logic [CNT_W-1:0] cnt;
    wire              cnt_done = (cnt == '0);

    // Bank state; counted states settle on the link tick
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || i_go_idle) begin
            state <= BK_IDLE;
            cnt   <= '0;
        end else if (i_act) begin
            state <= BK_ACTG;
            cnt   <= CNT_W'(RCD_CYC);
        end else if (i_rd) begin
            state <= i_ap ? BK_RDAP : BK_RD;
            cnt   <= CNT_W'(T_BURST_CK);
        end else if (i_wr) begin
            state <= i_ap ? BK_WRAP : BK_WR;
            cnt   <= CNT_W'(T_BURST_CK);
        end else if (i_pre) begin
            state <= BK_PRE;
            cnt   <= CNT_W'(RP_CYC);
        end else if (i_stop && (state == BK_RD || state == BK_WR)) begin
            state <= BK_ACT; // burst terminated [R8]
        end else if (i_tick) begin
            if (!cnt_done) begin
                cnt <= cnt - 1'b1;
            end else begin
                case (state)
                    BK_ACTG: state <= BK_ACT;            // after tRCD [R21]
                    BK_RD, BK_WR: state <= BK_ACT;
                    BK_RDAP, BK_WRAP: begin
                        state <= BK_PRE;
                        cnt   <= CNT_W'(RP_CYC);
                    end
                    BK_PRE: state <= BK_IDLE;            // after tRP [R21]
                    default: state <= state;
                endcase
            end
        end
    end

    assign o_state = state;
endmodule // bank_tracker
`default_nettype wire

// >>> tb/bank_cmd_chk.sv
// Concurrent checks on the command pins of the host controller
`timescale 1ns/1ps
`default_nettype none
module bank_cmd_chk
    import bank_cmd_pkg::*;
(
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_rst_n,
    input  wire logic                   o_req_ready,
    input  wire logic                   o_req_err,
    input  wire mem_cmd_s               o_mem_cmd,
    input  wire logic                   o_mem_cmd_valid,
    input  wire logic [MASK_W-1:0]      o_mem_dm,
    input  wire logic                   o_mem_dq_oe,
    input  wire logic [4*NUM_BANKS-1:0] o_bank_state
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    logic       vq;
    logic [5:0] gap;
    cmd_e       lc;
    // Start of each issued command
    wire rise = o_mem_cmd_valid && !vq;
    wire [3:0] cc = o_mem_cmd.cmd;
    // Cycles since the last command began, and its kind
    always_ff @(posedge i_ref_clk) begin
        vq <= o_mem_cmd_valid;
        if (!i_rst_n) gap <= 6'h3f;
        else if (rise) gap <= 6'h00;
        else if (gap != 6'h3f) gap <= gap + 6'h01;
    end
    always_ff @(posedge i_ref_clk) if (rise) lc <= o_mem_cmd.cmd;
    dm_idle_a: assert property (!o_mem_dq_oe |-> o_mem_dm == '1) else $error("mask not high");
    oe_write_a: assert property (o_mem_dq_oe |-> o_mem_cmd_valid && cc == CMD_WR)
        else $error("data driven without write");
    err_excl_a: assert property (!(o_mem_cmd_valid && o_req_err)) else $error("cmd and err");
    nop_idle_a: assert property (!o_mem_cmd_valid |-> cc == CMD_NOP) else $error("not NOP");
    cmd_hold_a: assert property (rise |=> o_mem_cmd_valid [*6]) else $error("cmd too short");
    mrw_gap_a: assert property (rise && lc == CMD_MRW |-> gap >= 6'h24)
        else $error("command inside write window");
    mrr_gap_a: assert property (rise && lc == CMD_MRR |-> gap >= 6'h0d)
        else $error("command inside read window");
    idle_only_a: assert property (rise && cc inside {CMD_MRW, CMD_REF, CMD_RESET}
        |-> $past(o_bank_state) == '0) else $error("all-bank cmd with bank busy");
    bst_burst_a: assert property (rise && cc == CMD_BST |-> $past(o_bank_state) != '0)
        else $error("terminate with no bank busy");
    mrw_ready_a: assert property (rise && cc == CMD_MRW |-> ##2 !o_req_ready [*6])
        else $error("ready during write window");
    c_bst: cover property (rise && cc == CMD_BST);
    c_err: cover property ($rose(o_req_err));
    c_mrr: cover property (rise && cc == CMD_MRR);
endmodule // bank_cmd_chk
bind bank_cmd_host bank_cmd_chk i_chk (.i_ref_clk, .i_rst_n, .o_req_ready, .o_req_err,
    .o_mem_cmd, .o_mem_cmd_valid, .o_mem_dm, .o_mem_dq_oe, .o_bank_state);
`default_nettype wire

// >>> tb/lpddr2_dev_model.sv
// Behavioural four-bank memory that receives the controller's commands
`timescale 1ns/1ps
`default_nettype none
module lpddr2_dev_model
    import bank_cmd_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_cke_en,
    input  wire mem_cmd_s          i_cmd,
    input  wire logic              i_cmd_valid,
    input  wire logic [DATA_W-1:0] i_dq,
    input  wire logic [MASK_W-1:0] i_dm,
    output logic                   o_ck,
    output logic                   o_cke,
    output logic [DATA_W-1:0]      o_word,
    output var int                 o_bad
);
    logic [1:0]        st [NUM_BANKS];
    logic [DATA_W-1:0] mem [NUM_BANKS];
    logic              seen = 1'b0;
    logic              up = 1'b0;
    // Any bank open or bursting
    wire busy = |{st[0], st[1], st[2], st[3]};
    // Free-running link clock
    initial begin
        o_ck = 1'b0;
        o_bad = 0;
        o_word = '0;
        for (int i = 0; i < NUM_BANKS; i++) st[i] = 2'h0;
        for (int i = 0; i < NUM_BANKS; i++) mem[i] = '0;
        forever #100 o_ck = ~o_ck;
    end
    always @(posedge o_ck) o_cke <= i_cke_en;
    // Command registration; 0 idle, 1 active, 2 bursting
    always @(posedge i_ref_clk) begin
        logic [DATA_W-1:0] w;
        w = mem[i_cmd.bank];
        seen <= i_cmd_valid;
        if (i_cmd_valid && !seen) begin
            case (i_cmd.cmd)
                CMD_RESET, CMD_MRW, CMD_REF: begin
                    if (busy) o_bad <= o_bad + 1;
                    up <= 1'b1;
                end
                CMD_ACT: begin
                    if (!up || st[i_cmd.bank] != 2'h0) o_bad <= o_bad + 1;
                    st[i_cmd.bank] <= 2'h1;
                end
                CMD_RD, CMD_WR: begin
                    if (st[i_cmd.bank] == 2'h0) o_bad <= o_bad + 1;
                    st[i_cmd.bank] <= 2'h2;
                    for (int i = 0; i < MASK_W; i++) if (!i_dm[i]) w[8*i+:8] = i_dq[8*i+:8];
                    if (i_cmd.cmd == CMD_WR) mem[i_cmd.bank] <= w;
                    if (i_cmd.cmd == CMD_WR) o_word <= w;
                end
                CMD_BST: begin
                    if (st[i_cmd.bank] != 2'h2) o_bad <= o_bad + 1;
                    st[i_cmd.bank] <= 2'h1;
                end
                CMD_PRE: st[i_cmd.bank] <= 2'h0;
                CMD_PREA: for (int i = 0; i < NUM_BANKS; i++) st[i] <= 2'h0;
                CMD_MRR: if (!up) o_bad <= o_bad + 1;
                default: o_bad <= o_bad + 1;
            endcase
        end
    end
endmodule // lpddr2_dev_model
`default_nettype wire

// >>> tb/lpddr2_interbank_command_rules_tb.sv
// Self-checking bench for the cross-bank host controller
`timescale 1ns/1ps
`default_nettype none
module lpddr2_interbank_command_rules_tb
    import bank_cmd_pkg::*;
;
    logic i_ref_clk, i_rst_n, i_req_valid, cke_en, mem_ck, mem_cke, rdy, err, vld, oe;
    user_req_s         req;
    mem_cmd_s          mcmd;
    logic [DATA_W-1:0] dq, word, wd;
    logic [MASK_W-1:0] dm, wm;
    logic [15:0]       state, lfsr;
    logic [DATA_W-1:0] shadow [NUM_BANKS];
    int                bad, error_cnt, n_checks;
    bank_cmd_host i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_mem_ck(mem_ck),
        .i_mem_cke(mem_cke), .i_req_valid(i_req_valid), .i_req(req), .o_req_ready(rdy),
        .o_req_err(err), .o_mem_cmd(mcmd), .o_mem_cmd_valid(vld), .o_mem_dq(dq),
        .o_mem_dm(dm), .o_mem_dq_oe(oe), .o_bank_state(state));
    lpddr2_dev_model i_dev (.i_ref_clk(i_ref_clk), .i_cke_en(cke_en), .i_cmd(mcmd),
        .i_cmd_valid(vld), .i_dq(dq), .i_dm(dm), .o_ck(mem_ck), .o_cke(mem_cke),
        .o_word(word), .o_bad(bad));
    // 40 MHz system clock
    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n,
                                                 input logic [MASK_W-1:0] m);
        for (int i = 0; i < MASK_W; i++) if (!m[i]) o[8*i+:8] = n[8*i+:8];
        return o;
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [DATA_W-1:0] s, e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One request held until answered, then checked
    task automatic send(input cmd_e c, input logic [1:0] b, input logic ap, e);
        int n;
        n = 0;
        while ((vld !== 1'b0 || err !== 1'b0) && n < 400) begin
            @(negedge i_ref_clk);
            n++;
        end
        lfsr = lfsr_next(lfsr);
        wd = {lfsr, ~lfsr ^ 16'h5a5a};
        wm = lfsr[3:0];
        @(posedge i_ref_clk);
        req <= '{c, b, ap, wd, wm};
        i_req_valid <= 1'b1;
        do begin
            @(negedge i_ref_clk);
            n++;
        end while (vld !== 1'b1 && err !== 1'b1 && n < 800);
        @(posedge i_ref_clk);
        i_req_valid <= 1'b0;
        @(negedge i_ref_clk);
        chk("answered", 32'(n < 800), 32'h0000_0001);
        chk("refused", err, e);
        if (!e) chk("command", mcmd, {c, b, ap});
        if (!e && c == CMD_WR) begin
            shadow[b] = merge(shadow[b], wd, wm);
            chk("dq", dq, wd);
            chk("dm", dm, wm);
            chk("stored", word, shadow[b]);
        end
        if (n >= 800) report_and_stop();
    endtask
    initial begin
        i_rst_n = 1'b0;
        i_req_valid = 1'b0;
        req = '0;
        cke_en = 1'b1;
        lfsr = 16'h3f9b;
        error_cnt = 0;
        n_checks = 0;
        for (int i = 0; i < NUM_BANKS; i++) shadow[i] = '0;
        repeat (20) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        repeat (40) @(posedge i_ref_clk);
        send(CMD_RD, 2'h0, 1'b0, 1'b1);
        send(CMD_RESET, 2'h0, 1'b0, 1'b0);
        send(CMD_MRR, 2'h0, 1'b0, 1'b0);
        repeat (40) @(negedge i_ref_clk);
        chk("banks idle", state, 16'h0000);
        send(CMD_MRW, 2'h0, 1'b0, 1'b0);
        send(CMD_ACT, 2'h0, 1'b0, 1'b0);
        send(CMD_ACT, 2'h1, 1'b0, 1'b0);
        send(CMD_ACT, 2'h2, 1'b0, 1'b0);
        send(CMD_RD, 2'h0, 1'b0, 1'b0);
        send(CMD_BST, 2'h0, 1'b0, 1'b0);
        send(CMD_BST, 2'h0, 1'b0, 1'b1);
        cke_en <= 1'b0;
        repeat (32) @(posedge i_ref_clk);
        fork
            send(CMD_MRR, 2'h1, 1'b0, 1'b0);
            begin
                repeat (60) @(negedge i_ref_clk);
                chk("held off", {rdy, vld}, 32'h0000_0000);
                @(posedge i_ref_clk);
                cke_en <= 1'b1;
            end
        join
        for (int k = 0; k < 6; k++) begin
            send(CMD_WR, 2'(lfsr % 3), 1'b0, 1'b0);
            repeat (24) @(posedge i_ref_clk);
        end
        send(CMD_WR, 2'h2, 1'b1, 1'b0);
        send(CMD_ACT, 2'h3, 1'b0, 1'b0);
        repeat (60) @(posedge i_ref_clk);
        send(CMD_WR, 2'h0, 1'b0, 1'b0);
        send(CMD_RD, 2'h1, 1'b0, 1'b1);
        send(CMD_RD, 2'h1, 1'b0, 1'b0);
        repeat (60) @(posedge i_ref_clk);
        send(CMD_PREA, 2'h0, 1'b0, 1'b0);
        repeat (60) @(negedge i_ref_clk);
        chk("idle after prea", state, 16'h0000);
        send(CMD_RD, 2'h1, 1'b0, 1'b1);
        send(CMD_REF, 2'h0, 1'b0, 1'b0);
        repeat (40) @(negedge i_ref_clk);
        chk("device saw illegal", bad, 32'h0000_0000);
        report_and_stop();
    end
endmodule // lpddr2_interbank_command_rules_tb
`default_nettype wire
